// ### hw/sdc_ctrl.sv
// SDRAM host-port controller: open row, refresh, bridge sharing
// Notes on behaviour
// [RULE_01] Host sees whole SDRAM as flat memory
// [RULE_02] No registers; every access reaches memory
// [RULE_03] Wait holds host until transfer proceeds
// [RULE_04] Pipelined reads: latency, then one per cycle
// [RULE_05] Refresh pauses host service periodically
// [RULE_06] SDRAM clock same frequency, phase outside
// [RULE_07] Clock enable held high, no power-down
// [RULE_08] Shared pins driven only while granted
// [RULE_09] One open row; hits served without reopening
// [RULE_10] Miss costs precharge plus activate
// [RULE_11] Keep bridge while back-to-back hits continue
// [RULE_12] Close row on idle gap or refresh
// [RULE_13] After losing bridge, regain grant, reopen row
// [RULE_14] Read data after CAS latency one to three
// [RULE_15] Reset runs one to eight init refreshes
// [RULE_16] Periodic auto-refresh, default 15.625 us
// [RULE_17] Host holds request during wait, awaits valid
// [RULE_18] Due refresh beats pending host transfers
`timescale 1ns/100ps
`include "sdc_params.svh"
module sdc_ctrl #(
  parameter int unsigned CAS_LAT    = 3,
  parameter int unsigned INIT_REFS  = 2,
  parameter bit          SHARE_PINS = 1'h0
) (
  input  wire logic                    mclk,
  input  wire logic                    nrst,
  input  wire logic                    bclk,
  input  wire logic                    nlrst,
  input  wire logic                    host_valid,
  input  wire sdc_pkg::sdc_req_t       host_req,
  output logic                         host_wait,
  output logic      [`SDC_DW-1:0]      host_rdata,
  output logic                         host_rvalid,
  output logic                         bridge_req,
  input  wire logic                    bridge_gnt,
  output logic                         sd_cke,
  output sdc_pkg::sdc_cmd_t            sd_cmd,
  output logic      [`SDC_BAW-1:0]     sd_ba,
  output logic      [`SDC_ROWW-1:0]    sd_addr,
  output logic      [`SDC_BEW-1:0]     sd_dqm,
  output logic                         sd_pin_oe,
  output logic      [`SDC_DW-1:0]      sd_dq_o,
  output logic                         sd_dq_oe,
  input  wire logic [`SDC_DW-1:0]      sd_dq_i
);

  localparam int RD_LAT = CAS_LAT + 3;

  localparam logic [`SDC_CNTW-1:0] LD_PWR =
    `SDC_CNTW'(`SDC_TPWR_CYC - 1);
  localparam logic [`SDC_CNTW-1:0] LD_RP =
    `SDC_CNTW'(`SDC_TRP_CYC - 1);
  localparam logic [`SDC_CNTW-1:0] LD_RCD =
    `SDC_CNTW'(`SDC_TRCD_CYC - 1);
  localparam logic [`SDC_CNTW-1:0] LD_RFC =
    `SDC_CNTW'(`SDC_TRFC_CYC - 1);
  localparam logic [`SDC_CNTW-1:0] LD_WR =
    `SDC_CNTW'(`SDC_TWR_CYC - 1);
  localparam logic [`SDC_CNTW-1:0] LD_MRD =
    `SDC_CNTW'(`SDC_TMRD_CYC - 1);
  localparam logic [`SDC_ROWW-1:0] MODE_WORD =
    `SDC_ROWW'(CAS_LAT << `SDC_MR_CL_LSB);

  sdc_pkg::sdc_state_t        state;
  sdc_pkg::sdc_state_t        next_state;
  sdc_pkg::sdc_state_t        pend;
  sdc_pkg::sdc_state_t        next_pend;
  logic [`SDC_CNTW-1:0]       cnt;
  logic [`SDC_CNTW-1:0]       next_cnt;
  logic [`SDC_REFW-1:0]       refs_left;
  logic [`SDC_REFW-1:0]       next_refs;
  logic [`SDC_BAW-1:0]        open_ba;
  logic [`SDC_ROWW-1:0]       open_row;
  logic [`SDC_PIPEW-1:0]      rd_pipe;
  logic                       want;
  logic                       do_act;
  logic                       do_pre;
  logic                       do_ref;
  logic                       do_mrs;
  logic                       do_rw;
  logic                       ref_due;
  logic                       gnt_s;

  // [RULE_01] flat address split
  wire [`SDC_BAW-1:0]  req_ba  = host_req.addr[`SDC_BA_LSB +: `SDC_BAW];
  wire [`SDC_ROWW-1:0] req_row = host_req.addr[`SDC_ROW_LSB +: `SDC_ROWW];
  wire [`SDC_COLW-1:0] req_col = host_req.addr[`SDC_COL_LSB +: `SDC_COLW];

  wire ready   = (cnt == '0);
  wire in_open = (state == sdc_pkg::st_open) & ready;
  // [RULE_09] open row hit
  wire hit     = (req_ba == open_ba) & (req_row == open_row);
  // Writes wait until read data has left dq, avoiding bus contention
  wire rd_busy = |rd_pipe;
  wire own     = want & gnt_s;

  // [RULE_02] every access goes to memory
  wire accept = in_open & host_valid & ~ref_due & hit
              & ~(host_req.wr & rd_busy);

  // [RULE_03] stall until accepted
  assign host_wait = host_valid & ~accept;

  // [RULE_07] clock enable fixed
  assign sd_cke = 1'h1;

  // [RULE_08] shared pins follow grant
  assign sd_pin_oe = ~SHARE_PINS | own;

  // [RULE_05] refresh interval source
  sdc_rtimer u_rtimer (
    .mclk (mclk),
    .nrst (nrst),
    .ack  (do_ref),
    .due  (ref_due)
  );

  // Bridge request crosses into the bridge clock domain
  sdc_sync #(.W(1)) u_req_sync (
    .clk  (bclk),
    .nrst (nlrst),
    .d    (want),
    .q    (bridge_req)
  );

  sdc_sync #(.W(1)) u_gnt_sync (
    .clk  (mclk),
    .nrst (nrst),
    .d    (bridge_gnt),
    .q    (gnt_s)
  );

  // [RULE_06] same-frequency capture
  sdc_sync #(.W(`SDC_DW)) u_dq_sync (
    .clk  (mclk),
    .nrst (nrst),
    .d    (sd_dq_i),
    .q    (host_rdata)
  );

  always_comb begin
    next_state = state;
    next_pend  = pend;
    next_refs  = refs_left;
    next_cnt   = ready ? cnt : cnt - `SDC_CNTW'(1);
    do_act     = 1'h0;
    do_pre     = 1'h0;
    do_ref     = 1'h0;
    do_mrs     = 1'h0;
    do_rw      = 1'h0;
    case (state)
      sdc_pkg::st_pwr: begin
        if (ready && (gnt_s || !SHARE_PINS)) begin
          do_pre     = 1'h1;
          next_state = sdc_pkg::st_ipre;
        end
      end
      // [RULE_15] init refresh sequence
      sdc_pkg::st_ipre: begin
        if (ready) begin
          do_ref     = 1'h1;
          next_refs  = refs_left - `SDC_REFW'(1);
          next_state = sdc_pkg::st_iref;
        end
      end
      sdc_pkg::st_iref: begin
        if (ready && refs_left == '0) begin
          do_mrs     = 1'h1;
          next_state = sdc_pkg::st_imrs;
        end else if (ready) begin
          do_ref     = 1'h1;
          next_refs  = refs_left - `SDC_REFW'(1);
        end
      end
      sdc_pkg::st_imrs: begin
        if (ready) begin
          next_state = sdc_pkg::st_idle;
        end
      end
      // [RULE_18] refresh before host work
      sdc_pkg::st_idle: begin
        if (ref_due) begin
          do_ref     = 1'h1;
          next_state = sdc_pkg::st_ref;
        end else if (host_valid && !SHARE_PINS) begin
          do_act = 1'h1;
        end else if (host_valid && !gnt_s) begin
          next_state = sdc_pkg::st_gnt;
        end
      end
      // [RULE_13] regain grant before reopening
      sdc_pkg::st_gnt: begin
        if (ref_due) begin
          next_state = sdc_pkg::st_idle;
        end else if (gnt_s) begin
          do_act = 1'h1;
        end
      end
      sdc_pkg::st_act: begin
        if (ready) begin
          next_state = sdc_pkg::st_open;
        end
      end
      sdc_pkg::st_open: begin
        if (ready && ref_due) begin
          // [RULE_12] close row for refresh
          do_pre     = 1'h1;
          next_pend  = sdc_pkg::st_ref;
          next_state = sdc_pkg::st_pre;
        end else if (accept) begin
          // [RULE_04] one access per cycle
          do_rw = 1'h1;
        end else if (ready && host_valid && !hit) begin
          // [RULE_10] miss reopens row
          do_pre     = 1'h1;
          next_pend  = sdc_pkg::st_act;
          next_state = sdc_pkg::st_pre;
        end else if (ready && !host_valid) begin
          // [RULE_12] close row on gap
          do_pre     = 1'h1;
          next_pend  = sdc_pkg::st_idle;
          next_state = sdc_pkg::st_pre;
        end
      end
      sdc_pkg::st_pre: begin
        if (ready && (pend == sdc_pkg::st_ref || ref_due)) begin
          do_ref     = 1'h1;
          next_state = sdc_pkg::st_ref;
        end else if (ready && pend == sdc_pkg::st_act && host_valid) begin
          do_act = 1'h1;
        end else if (ready) begin
          next_state = sdc_pkg::st_idle;
        end
      end
      sdc_pkg::st_ref: begin
        if (ready) begin
          next_state = sdc_pkg::st_idle;
        end
      end
      default: begin
        next_state = sdc_pkg::st_pwr;
      end
    endcase
    if (do_pre) begin
      next_cnt = LD_RP;
    end
    if (do_ref) begin
      next_cnt = LD_RFC;
    end
    if (do_mrs) begin
      next_cnt = LD_MRD;
    end
    if (do_act) begin
      next_cnt   = LD_RCD;
      next_state = sdc_pkg::st_act;
    end
    if (do_rw && host_req.wr) begin
      next_cnt = LD_WR;
    end
  end

  // [RULE_11] hold bridge while row open
  wire next_want = SHARE_PINS
                 & (next_state != sdc_pkg::st_idle)
                 & (next_state != sdc_pkg::st_ref);

  wire [3:0] next_cmd =
    do_act ? `SDC_CMD_ACT :
    do_pre ? `SDC_CMD_PRE :
    do_ref ? `SDC_CMD_REF :
    do_mrs ? `SDC_CMD_MRS :
    do_rw  ? (host_req.wr ? `SDC_CMD_WR : `SDC_CMD_RD) :
    `SDC_CMD_NOP;

  wire [`SDC_ROWW-1:0] next_addr =
    do_act ? req_row :
    do_pre ? `SDC_ADDR_PALL :
    do_mrs ? MODE_WORD :
    do_rw  ? `SDC_ROWW'(req_col) :
    sd_addr;

  wire [`SDC_BAW-1:0]  next_ba  = (do_act | do_rw) ? req_ba : sd_ba;
  wire                 wr_go    = do_rw & host_req.wr;
  wire [`SDC_BEW-1:0]  next_dqm = do_rw ? (wr_go ? ~host_req.be : '0)
                                        : sd_dqm;
  wire [`SDC_DW-1:0]   next_dq  = wr_go ? host_req.wdata : sd_dq_o;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state     <= sdc_pkg::st_pwr;
      pend      <= sdc_pkg::st_idle;
      cnt       <= LD_PWR;
      refs_left <= `SDC_REFW'(INIT_REFS);
      want      <= 1'h0;
    end else begin
      state     <= next_state;
      pend      <= next_pend;
      cnt       <= next_cnt;
      refs_left <= next_refs;
      want      <= next_want;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sd_cmd   <= `SDC_CMD_NOP;
      sd_ba    <= '0;
      sd_addr  <= '0;
      sd_dqm   <= `SDC_DQM_OFF;
      sd_dq_o  <= '0;
      sd_dq_oe <= 1'h0;
    end else begin
      sd_cmd   <= next_cmd;
      sd_ba    <= next_ba;
      sd_addr  <= next_addr;
      sd_dqm   <= next_dqm;
      sd_dq_o  <= next_dq;
      sd_dq_oe <= wr_go;
    end
  end

  // [RULE_14] read return pipeline
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      open_ba  <= '0;
      open_row <= '0;
      rd_pipe  <= '0;
    end else begin
      if (do_act) begin
        open_ba  <= req_ba;
        open_row <= req_row;
      end
      rd_pipe <= {rd_pipe[`SDC_PIPEW-2:0], do_rw & ~host_req.wr};
    end
  end

  assign host_rvalid = rd_pipe[CAS_LAT + 2];

  wire [3:0] cmd_bits = sd_cmd;

  cke_high_a: // [RULE_07]
  assert property (@(posedge mclk) disable iff (!nrst)
    sd_cke ##1 sd_cke)
    else $error("clock enable dropped");

  dq_owned_a: // [RULE_08]
  assert property (@(posedge mclk) disable iff (!nrst)
    sd_dq_oe |-> sd_pin_oe && (!SHARE_PINS || gnt_s))
    else $error("dq driven without bridge grant");

  rd_latency_a: // [RULE_14]
  assert property (@(posedge mclk) disable iff (!nrst)
    (accept && !host_req.wr) |-> ##RD_LAT host_rvalid)
    else $error("read data not valid at CAS latency");

  acc_cmd_a: // [RULE_03]
  assert property (@(posedge mclk) disable iff (!nrst)
    (host_valid && !host_wait) |=>
      (cmd_bits == (($past(host_req.wr)) ? `SDC_CMD_WR : `SDC_CMD_RD)))
    else $error("accepted transfer issued no access command");

  hit_bank_a: // [RULE_09]
  assert property (@(posedge mclk) disable iff (!nrst)
    (cmd_bits == `SDC_CMD_RD || cmd_bits == `SDC_CMD_WR)
      |-> (sd_ba == open_ba) && (state == sdc_pkg::st_open))
    else $error("access outside the open row bank");

  miss_pre_a: // [RULE_10]
  assert property (@(posedge mclk) disable iff (!nrst)
    (in_open && host_valid && !hit && !ref_due) |=>
      (cmd_bits == `SDC_CMD_PRE) ##[1:4]
      (cmd_bits == `SDC_CMD_ACT || cmd_bits == `SDC_CMD_REF))
    else $error("row miss not followed by precharge and activate");

  gap_close_a: // [RULE_12]
  assert property (@(posedge mclk) disable iff (!nrst)
    (in_open && !host_valid) |=> (cmd_bits == `SDC_CMD_PRE))
    else $error("row left open after idle gap");

  ref_first_a: // [RULE_18]
  assert property (@(posedge mclk) disable iff (!nrst)
    (in_open && ref_due) |-> host_wait || !host_valid
      ##1 (cmd_bits == `SDC_CMD_PRE) ##[1:4] (cmd_bits == `SDC_CMD_REF))
    else $error("refresh not given priority");

  act_grant_a: // [RULE_13]
  assert property (@(posedge mclk) disable iff (!nrst)
    (SHARE_PINS && cmd_bits == `SDC_CMD_ACT) |-> $past(gnt_s) && want)
    else $error("row opened without bridge grant");

  keep_bus_a: // [RULE_11]
  assert property (@(posedge mclk) disable iff (!nrst)
    (SHARE_PINS && accept) |=> want [*2])
    else $error("bridge released during back-to-back hits");

endmodule

// ### pkg/sdc_params.svh
// Constants for the SDRAM host-port controller
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

// Geometry: 4 banks, 4096 rows, 256 columns, 32-bit words
`define SDC_DW         32
`define SDC_BEW        4
`define SDC_BAW        2
`define SDC_ROWW       12
`define SDC_COLW       8
`define SDC_AW         22
`define SDC_COL_LSB    0
`define SDC_ROW_LSB    8
`define SDC_BA_LSB     20
`define SDC_CNTW       12
`define SDC_REFW       4
`define SDC_PIPEW      8

// Times in ns, cycle counts derived from the 40 MHz controller clock
`define SDC_CLK_NS     25
`define SDC_TREF_NS    15625
`define SDC_TREF_CYC   (`SDC_TREF_NS / `SDC_CLK_NS)
`define SDC_TPWR_NS    100000
`define SDC_TPWR_CYC   ((`SDC_TPWR_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_TRP_NS     20
`define SDC_TRP_CYC    ((`SDC_TRP_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_TRCD_NS    20
`define SDC_TRCD_CYC   ((`SDC_TRCD_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_TRFC_NS    70
`define SDC_TRFC_CYC   ((`SDC_TRFC_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_TWR_NS     15
`define SDC_TWR_CYC    ((`SDC_TWR_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_TMRD_NS    50
`define SDC_TMRD_CYC   ((`SDC_TMRD_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)

// Commands as {cs_n, ras_n, cas_n, we_n}
`define SDC_CMD_NOP    4'h7
`define SDC_CMD_ACT    4'h3
`define SDC_CMD_RD     4'h5
`define SDC_CMD_WR     4'h4
`define SDC_CMD_PRE    4'h2
`define SDC_CMD_REF    4'h1
`define SDC_CMD_MRS    4'h0

`define SDC_ADDR_PALL  12'h400
`define SDC_MR_CL_LSB  4
`define SDC_DQM_OFF    4'hF

`endif

// ### pkg/sdc_pkg.sv
// Types shared by the SDRAM host-port controller
`include "sdc_params.svh"
package sdc_pkg;

  typedef enum logic [9:0] {
    st_pwr  = 10'h001,
    st_ipre = 10'h002,
    st_iref = 10'h004,
    st_imrs = 10'h008,
    st_idle = 10'h010,
    st_gnt  = 10'h020,
    st_act  = 10'h040,
    st_open = 10'h080,
    st_pre  = 10'h100,
    st_ref  = 10'h200
  } sdc_state_t;

  typedef struct packed {
    logic                 wr;
    logic [`SDC_AW-1:0]   addr;
    logic [`SDC_DW-1:0]   wdata;
    logic [`SDC_BEW-1:0]  be;
  } sdc_req_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdc_cmd_t;

endpackage

// ### hw/sdc_sync.sv
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/100ps
module sdc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ### hw/sdc_rtimer.sv
// Periodic refresh interval timer with sticky due flag
`timescale 1ns/100ps
`include "sdc_params.svh"
module sdc_rtimer (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic ack,
  output logic      due
);

  localparam logic [`SDC_CNTW-1:0] RELOAD =
    `SDC_CNTW'(`SDC_TREF_CYC - 1);

  logic [`SDC_CNTW-1:0] cnt;
  wire                  expire = (cnt == '0);

  // [RULE_16] interval countdown
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt <= RELOAD;
      due <= 1'h0;
    end else begin
      cnt <= expire ? RELOAD : cnt - `SDC_CNTW'(1);
      // A new expiry wins over a same-cycle acknowledge
      due <= expire | (due & ~ack);
    end
  end

  due_set_a: // [RULE_16]
  assert property (@(posedge mclk) disable iff (!nrst)
    expire |=> due)
    else $error("refresh due not raised at interval end");

endmodule

// ### sim/sdc_sdram_model.sv
// SDRAM chip model: open-row tracking, byte masks, CAS-latency reads
`timescale 1ns/100ps
`include "sdc_params.svh"
module sdc_sdram_model #(
  parameter int unsigned CAS_LAT = 3
) (
  input  wire logic              clk,
  input  wire logic              cke,
  input  wire sdc_pkg::sdc_cmd_t cmd,
  input  wire logic [1:0]        ba,
  input  wire logic [11:0]       addr,
  input  wire logic [3:0]        dqm,
  input  wire logic              dq_oe,
  input  wire logic [31:0]       dq_o,
  output logic      [31:0]       dq,
  output int                     errs
);
  logic [11:0] row [4];
  logic [3:0]  open_b;
  logic [31:0] mem [int];
  logic [31:0] w;
  int          i;
  initial begin
    dq = 32'h0;
    errs = 0;
    open_b = 4'h0;
  end
  // data valid CAS_LAT edges after the read
  // Bus shows the inverse afterwards so stale data never passes
  task automatic give(input logic [31:0] d);
    repeat (CAS_LAT - 1) @(posedge clk);
    #2 dq = d;
    @(posedge clk);
    #1 dq = ~d;
  endtask
  // clocked by the controller clock itself
  always @(posedge clk) begin
    i = {ba, row[ba], addr[7:0]};
    w = mem.exists(i) ? mem[i] : 32'h0;
    if (cke !== 1'b1)
      errs++;
    case (cmd)
      // one open row, close before reopening
      `SDC_CMD_ACT: begin
        if (open_b != 4'h0)
          errs++;
        open_b[ba] = 1'b1;
        row[ba] = addr;
      end
      `SDC_CMD_PRE: open_b = addr[10] ? 4'h0 : open_b & ~(4'h1 << ba);
      `SDC_CMD_REF: if (open_b != 4'h0) errs++;
      `SDC_CMD_RD: begin
        if (!open_b[ba])
          errs++;
        fork
          give(w);
        join_none
      end
      `SDC_CMD_WR: begin
        if (!open_b[ba] || !dq_oe)
          errs++;
        for (int b = 0; b < 4; b++)
          if (!dqm[b])
            w[8*b+:8] = dq_o[8*b+:8];
        mem[i] = w;
      end
      default: ;
    endcase
  end
endmodule

// ### sim/sdc_ctrl_test.sv
// Self-checking bench for the SDRAM host-port controller
`timescale 1ns/100ps
`include "sdc_params.svh"
module sdc_ctrl_test;
  localparam int CL = 2;
  localparam int IR = 3;
  logic              mclk = 0;
  logic              bclk = 0;
  logic              nrst = 0;
  logic              nlrst = 0;
  logic              host_valid = 0;
  logic              bridge_gnt = 0;
  logic              busy = 0;
  sdc_pkg::sdc_req_t host_req = '0;
  sdc_pkg::sdc_cmd_t sd_cmd;
  logic              host_wait, host_rvalid, bridge_req;
  logic              sd_cke, sd_pin_oe, sd_dq_oe;
  logic [31:0]       host_rdata, sd_dq_o, sd_dq_i;
  logic [1:0]        sd_ba;
  logic [11:0]       sd_addr;
  logic [3:0]        sd_dqm;
  int                n_fail = 0, checks = 0, cyc = 0, errs;
  int                n_ref = 0, n_act = 0, n_pre = 0, n_mrs = 0;
  int                init_refs = 0, bad_pin = 0, last_ref = 0;
  int                ref_gap = 0;
  logic [31:0]       mirror [int];
  logic [31:0]       exp_d[$], got_d[$];
  int                exp_c[$], got_c[$], waits[$];

  always #12.5 mclk = ~mclk;
  always #40 bclk = ~bclk;

  sdc_ctrl #(.CAS_LAT(CL), .INIT_REFS(IR), .SHARE_PINS(1'b1)) i_dut (
    .mclk, .nrst, .bclk, .nlrst, .host_valid, .host_req, .host_wait,
    .host_rdata, .host_rvalid, .bridge_req, .bridge_gnt, .sd_cke,
    .sd_cmd, .sd_ba, .sd_addr, .sd_dqm, .sd_pin_oe, .sd_dq_o,
    .sd_dq_oe, .sd_dq_i);
  sdc_sdram_model #(.CAS_LAT(CL)) i_mem (.clk(mclk), .cke(sd_cke),
    .cmd(sd_cmd), .ba(sd_ba), .addr(sd_addr), .dqm(sd_dqm),
    .dq_oe(sd_dq_oe), .dq_o(sd_dq_o), .dq(sd_dq_i), .errs(errs));

  // Four-phase arbiter; busy stands for another device on the bridge
  always @(posedge bclk)
    bridge_gnt <= bridge_gnt ? bridge_req : bridge_req & !busy;

  always @(posedge mclk)
    cyc <= cyc + 1;

  always @(negedge mclk) begin
    if (host_rvalid) begin
      got_d.push_back(host_rdata);
      got_c.push_back(cyc);
    end
    if (sd_cmd == `SDC_CMD_REF) begin
      n_ref++;
      ref_gap = cyc - last_ref;
      last_ref = cyc;
      if (n_mrs == 0)
        init_refs++;
    end
    if (sd_cmd == `SDC_CMD_ACT)
      n_act++;
    if (sd_cmd == `SDC_CMD_PRE)
      n_pre++;
    if (sd_cmd == `SDC_CMD_MRS)
      n_mrs++;
    if (sd_pin_oe && !bridge_gnt || sd_dq_oe && !sd_pin_oe)
      bad_pin++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  function automatic sdc_pkg::sdc_req_t mk(input logic wr,
    input logic [21:0] a, input logic [31:0] d, input logic [3:0] be);
    mk = '{wr, a, d, be};
  endfunction

  // host holds request
  // Host side: hold each request until wait drops, then the next
  task automatic run(input sdc_pkg::sdc_req_t q[$]);
    int n;
    logic [31:0] m;
    waits.delete();
    foreach (q[i]) begin
      host_valid <= 1'b1;
      host_req <= q[i];
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while (host_wait !== 1'b0 && n < 3000);
      waits.push_back(n - 1);
      m = mirror.exists(q[i].addr) ? mirror[q[i].addr] : 32'h0;
      if (!q[i].wr) begin
        exp_d.push_back(m);
        exp_c.push_back(cyc + CL + 3);
      end
      for (int b = 0; b < 4; b++)
        if (q[i].wr && q[i].be[b])
          m[8*b+:8] = q[i].wdata[8*b+:8];
      mirror[q[i].addr] = m;
      @(posedge mclk);
    end
    host_valid <= 1'b0;
  endtask

  task automatic drain;
    repeat (CL + 8) @(posedge mclk);
    check(got_d.size(), exp_d.size());
    while (got_d.size() > 0 && exp_d.size() > 0) begin
      check(got_d.pop_front(), exp_d.pop_front());
      check(got_c.pop_front(), exp_c.pop_front());
    end
    got_d.delete();
    exp_d.delete();
    got_c.delete();
    exp_c.delete();
  endtask

  task automatic after_ref(input int extra);
    int r;
    r = n_ref;
    for (int i = 0; i < 700 && n_ref == r; i++)
      @(posedge mclk);
    repeat (extra) @(posedge mclk);
  endtask

  task automatic t_init;
    check(init_refs, IR);
    check(sd_cke, 1'b1);
  endtask

  task automatic t_banks;
    int a;
    after_ref(5);
    a = n_act;
    run('{mk(1, 22'h000000, 32'h11223344, 4'hF),
      mk(1, 22'h3FFFFF, 32'hA5A5A5A5, 4'hF),
      mk(1, 22'h105007, 32'hCAFEF00D, 4'h5),
      mk(1, 22'h000000, 32'hFFFFFFFF, 4'h2),
      mk(0, 22'h000000, 0, 0), mk(0, 22'h3FFFFF, 0, 0),
      mk(0, 22'h105007, 0, 0)});
    check(waits[1] >= 2, 1'b1);
    check(n_act - a, 6);
    drain;
  endtask

  task automatic t_stream;
    sdc_pkg::sdc_req_t q[$];
    int a, p;
    after_ref(5);
    for (int i = 0; i < 16; i++)
      q.push_back(mk(i < 8, 22'h2ABC00 + i % 8, 32'hBEEF0000 + i, 4'hF));
    a = n_act;
    run(q);
    check(bridge_req, 1'b1);
    check(n_act - a, 1);
    check(waits.sum() - waits[0] - waits[8], 0);
    p = n_pre;
    repeat (20) @(posedge mclk);
    check(n_pre - p, 1);
    check(bridge_req, 1'b0);
    drain;
  endtask

  task automatic t_refresh;
    sdc_pkg::sdc_req_t q[$];
    int r;
    after_ref(0);
    after_ref(580);
    check(ref_gap, `SDC_TREF_CYC);
    for (int i = 0; i < 60; i++)
      q.push_back(mk(0, 22'h2ABC00 + i % 8, 0, 0));
    r = n_ref;
    run(q);
    check(n_ref - r, 1);
    check(waits.sum() > 0, 1'b1);
    drain;
  endtask

  task automatic t_grant;
    int a;
    repeat (30) @(posedge mclk);
    @(posedge bclk) busy <= 1'b1;
    @(posedge mclk);
    a = n_act;
    fork
      run('{mk(1, 22'h155555, 32'h0BADCAFE, 4'hF),
        mk(0, 22'h155555, 0, 0)});
      begin
        repeat (40) @(negedge mclk);
        check(host_wait, 1'b1);
        check(n_act - a, 0);
        @(posedge bclk) busy <= 1'b0;
      end
    join
    drain;
    check(bad_pin, 0);
  endtask

  task automatic finish_test;
    check(errs, 0);
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge bclk);
    nlrst <= 1'b1;
  end

  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 6000 && n_mrs == 0; i++)
      @(posedge mclk);
    repeat (10) @(posedge mclk);
    t_init;
    t_banks;
    t_stream;
    t_refresh;
    t_grant;
    finish_test;
  end
endmodule
